/* inc/icap_defines.svh */
// Offsets, field positions and reset values of the input capture timer.
// Assumes a 32-bit APB bus with 12-bit byte addresses.
`ifndef ICAP_DEFINES_SVH
`define ICAP_DEFINES_SVH

// Byte offsets, one aligned word each
`define ICAP_OFF_PCE 12'h000
`define ICAP_OFF_MODE 12'h004
`define ICAP_OFF_CTRL 12'h008
`define ICAP_OFF_IOC 12'h00C
`define ICAP_OFF_IEN 12'h010
`define ICAP_OFF_STAT 12'h014
`define ICAP_OFF_MASK 12'h018
`define ICAP_OFF_CNT 12'h01C
`define ICAP_OFF_GRA 12'h020
`define ICAP_OFF_GRB 12'h024

// Field positions
`define ICAP_PCE_GATE 6
`define ICAP_MODE_RUN 7
`define ICAP_MODE_FCK_HI 5
`define ICAP_MODE_FCK_LO 4
`define ICAP_MODE_DFB 3
`define ICAP_MODE_DFA 2
`define ICAP_CTRL_CK_HI 2
`define ICAP_IOC_A_HI 2
`define ICAP_IOC_B_HI 6
`define ICAP_IOC_B_LO 4
`define ICAP_IOC_MODE_BIT 2
`define ICAP_EV_IMFA 0
`define ICAP_EV_IMFB 1
`define ICAP_EV_OVF 3
`define ICAP_MASK_BIT 3

// Reset values
`define ICAP_MASK_RST 1'b1
`define ICAP_IOC_RST 3'h0
`define ICAP_EV_RST 4'h0
`define ICAP_FCK_RST 2'h0
`define ICAP_CK_RST 3'h0

`endif

/* inc/icap_pkg.sv */
// Types shared by the input capture timer files.
// Encodings only; offsets and fields are in the defines header.
package icap_pkg;

    // Valid capture edge
    typedef enum logic [1:0] {
        ICAP_EDGE_RISE = 2'h0,
        ICAP_EDGE_FALL = 2'h1,
        ICAP_EDGE_BOTH = 2'h2,
        ICAP_EDGE_NONE = 2'h3
    } icap_edge_t;

    // Counter count source
    typedef enum logic [2:0] {
        ICAP_CK_DIV1 = 3'h0,
        ICAP_CK_DIV2 = 3'h1,
        ICAP_CK_DIV4 = 3'h2,
        ICAP_CK_DIV8 = 3'h3,
        ICAP_CK_DIV32 = 3'h4
    } icap_cksrc_t;

    // Digital filter sampling clock
    typedef enum logic [1:0] {
        ICAP_FCK_DIV32 = 2'h0,
        ICAP_FCK_DIV8 = 2'h1,
        ICAP_FCK_DIV1 = 2'h2,
        ICAP_FCK_CNT = 2'h3
    } icap_fck_t;

endpackage

/* src/icap_edge_filter.sv */
// One capture input path: two-stage synchroniser, optional digital filter, edge pulses.
// Assumes pin_i is asynchronous and sample_i is a one-cycle strobe on clk_i.
`timescale 1ns/10ps

module icap_edge_filter #(
    parameter int FILT_LEN = 3
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic clear_i,
    input wire logic pin_i,
    input wire logic filt_en_i,
    input wire logic sample_i,
    output logic rise_o,
    output logic fall_o
);

    logic sync1_reg;
    logic sync2_reg;
    logic [FILT_LEN-1:0] shift_reg;
    logic [FILT_LEN-1:0] shift_next;
    logic level_reg;
    logic level_next;

    // Next values; sync1 feeds only sync2
    always_comb begin
        shift_next = shift_reg;
        level_next = level_reg;
        if (clear_i) begin
            // Preload with the pin so enabling the timer gives no false edge
            shift_next = {FILT_LEN{sync2_reg}};
            level_next = sync2_reg;
        end else if (filt_en_i) begin
            if (sample_i) begin
                shift_next = {shift_reg[FILT_LEN-2:0], sync2_reg};
            end
            // Level moves only after FILT_LEN equal samples
            if (&shift_reg) begin
                level_next = 1'b1;
            end else if (~|shift_reg) begin
                level_next = 1'b0;
            end
        end else begin
            shift_next = {FILT_LEN{sync2_reg}};
            level_next = sync2_reg;
        end
    end

    // Registers
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            shift_reg <= '0;
            level_reg <= 1'b0;
        end else begin
            sync1_reg <= pin_i;
            sync2_reg <= sync1_reg;
            shift_reg <= shift_next;
            level_reg <= level_next;
        end
    end

    // Edges seen one cycle before the level register follows
    assign rise_o = level_next & ~level_reg & ~clear_i;
    assign fall_o = ~level_next & level_reg & ~clear_i;

endmodule // icap_edge_filter

/* src/icap_timer.sv */
// Input capture timer: free-running counter, two capture registers, APB slave.
// Assumes one 50 MHz clock, a synchronous APB master and asynchronous pins.
// What this block does
// - valid edge on pin A or B copies counter into general register A or B
// - valid edge is selectable as rising only, falling only or both edges
// - edge select pattern 10B on channel A means both edges of pin A
// - writing 1 to the run bit starts counting, 0 stops it
// - with the clock gate at 0 the timer stops and ignores register writes
// - with the clock gate off the whole timer is held in reset
// - with the clock gate at 1 all timer registers are readable and all but CNT, GRA and GRB are writable
// - a completed capture on an enabled channel requests the timer interrupt
// - counter overflow can raise the timer interrupt when enabled
// - count source selection includes the undivided peripheral clock
// - a switchable digital filter sits on each capture input
// - with the filter on, an edge is seen after up to five sample clocks
// - channel mode bit 1 makes the general register an input capture register
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/10ps
`include "icap_defines.svh"

module icap_timer import icap_pkg::*; #(
    parameter int CNT_W = 16,
    parameter int FILT_LEN = 3
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic capture_pin_a_i,
    input wire logic capture_pin_b_i,
    output logic timer_irq_o
);

    // Register state
    logic timer_clock_gate_reg, timer_clock_gate_next;
    logic count_run_reg, count_run_next;
    logic [1:0] filter_clock_select_reg, filter_clock_select_next;
    logic filter_enable_a_reg, filter_enable_a_next;
    logic filter_enable_b_reg, filter_enable_b_next;
    logic [2:0] cksrc_reg, cksrc_next;
    logic [2:0] ioc_a_reg, ioc_a_next;
    logic [2:0] ioc_b_reg, ioc_b_next;
    logic [3:0] irq_en_reg, irq_en_next;
    logic [3:0] event_reg, event_next;
    logic timer_irq_mask_reg, timer_irq_mask_next;
    logic [CNT_W-1:0] capture_counter_reg, capture_counter_next;
    logic [CNT_W-1:0] general_reg_a_reg, general_reg_a_next;
    logic [CNT_W-1:0] general_reg_b_reg, general_reg_b_next;
    logic [4:0] presc_reg, presc_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic [31:0] prdata_reg, prdata_next;
    logic irq_reg, irq_next;

    // Decoded strobes and events
    logic timer_clear;
    logic wr_strobe;
    logic addr_hit;
    logic cnt_tick;
    logic filt_tick;
    logic overflow;
    logic rise_a, fall_a, rise_b, fall_b;
    logic cap_a, cap_b;
    logic [3:0] event_set, event_clr;

    // Gate off keeps every timer register at its reset value
    assign timer_clear = ~timer_clock_gate_reg;

    // Writes land at the edge where the access phase is answered
    assign wr_strobe = psel_i & penable_i & pwrite_i & pready_reg;

    // Count source ticks from a shared prescaler
    always_comb begin
        unique case (icap_cksrc_t'(cksrc_reg))
            ICAP_CK_DIV1: cnt_tick = 1'b1;
            ICAP_CK_DIV2: cnt_tick = presc_reg[0];
            ICAP_CK_DIV4: cnt_tick = &presc_reg[1:0];
            ICAP_CK_DIV8: cnt_tick = &presc_reg[2:0];
            ICAP_CK_DIV32: cnt_tick = &presc_reg;
            default: cnt_tick = 1'b0; // External sources not wired: no count
        endcase
    end

    // Filter sampling clock selection
    always_comb begin
        unique case (icap_fck_t'(filter_clock_select_reg))
            ICAP_FCK_DIV32: filt_tick = &presc_reg;
            ICAP_FCK_DIV8: filt_tick = &presc_reg[2:0];
            ICAP_FCK_DIV1: filt_tick = 1'b1;
            ICAP_FCK_CNT: filt_tick = cnt_tick;
        endcase
    end

    // Per-channel synchroniser, filter and edge detector
    icap_edge_filter #(
        .FILT_LEN(FILT_LEN)
    ) u_path_a (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .clear_i(timer_clear),
        .pin_i(capture_pin_a_i),
        .filt_en_i(filter_enable_a_reg),
        .sample_i(filt_tick),
        .rise_o(rise_a),
        .fall_o(fall_a)
    );

    icap_edge_filter #(
        .FILT_LEN(FILT_LEN)
    ) u_path_b (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .clear_i(timer_clear),
        .pin_i(capture_pin_b_i),
        .filt_en_i(filter_enable_b_reg),
        .sample_i(filt_tick),
        .rise_o(rise_b),
        .fall_o(fall_b)
    );

    // Edge qualification; only capture mode channels take edges
    function automatic logic edge_ok(input logic [1:0] sel, input logic rise, input logic fall);
        unique case (icap_edge_t'(sel))
            ICAP_EDGE_RISE: edge_ok = rise;
            ICAP_EDGE_FALL: edge_ok = fall;
            ICAP_EDGE_BOTH: edge_ok = rise | fall;
            ICAP_EDGE_NONE: edge_ok = 1'b0;
        endcase
    endfunction

    assign cap_a = count_run_reg & ioc_a_reg[`ICAP_IOC_MODE_BIT]
        & edge_ok(ioc_a_reg[1:0], rise_a, fall_a);
    assign cap_b = count_run_reg & ioc_b_reg[`ICAP_IOC_MODE_BIT]
        & edge_ok(ioc_b_reg[1:0], rise_b, fall_b);
    assign overflow = count_run_reg & cnt_tick & (&capture_counter_reg);

    // Event sources and write-one-to-clear strobes
    always_comb begin
        event_set = '0;
        event_set[`ICAP_EV_IMFA] = cap_a;
        event_set[`ICAP_EV_IMFB] = cap_b;
        event_set[`ICAP_EV_OVF] = overflow;
        event_clr = '0;
        if (wr_strobe && paddr_i == `ICAP_OFF_STAT) begin
            event_clr = pwdata_i[3:0];
        end
    end

    // Timer core: counter, prescaler, captures and sticky events
    always_comb begin
        presc_next = presc_reg + 5'h1;
        capture_counter_next = capture_counter_reg;
        general_reg_a_next = general_reg_a_reg;
        general_reg_b_next = general_reg_b_reg;
        // A new event beats a clear in the same cycle
        event_next = (event_reg & ~event_clr) | event_set;
        if (count_run_reg && cnt_tick) begin
            capture_counter_next = capture_counter_reg + {{(CNT_W-1){1'b0}}, 1'b1};
        end
        if (cap_a) begin
            general_reg_a_next = capture_counter_reg;
        end
        if (cap_b) begin
            general_reg_b_next = capture_counter_reg;
        end
        if (timer_clear) begin
            presc_next = '0;
            capture_counter_next = '0;
            general_reg_a_next = '0;
            general_reg_b_next = '0;
            event_next = `ICAP_EV_RST;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            presc_reg <= '0;
            capture_counter_reg <= '0;
            general_reg_a_reg <= '0;
            general_reg_b_reg <= '0;
            event_reg <= `ICAP_EV_RST;
        end else begin
            presc_reg <= presc_next;
            capture_counter_reg <= capture_counter_next;
            general_reg_a_reg <= general_reg_a_next;
            general_reg_b_reg <= general_reg_b_next;
            event_reg <= event_next;
        end
    end

    // Configuration; timer registers refuse writes while gated
    always_comb begin
        timer_clock_gate_next = timer_clock_gate_reg;
        count_run_next = count_run_reg;
        filter_clock_select_next = filter_clock_select_reg;
        filter_enable_a_next = filter_enable_a_reg;
        filter_enable_b_next = filter_enable_b_reg;
        cksrc_next = cksrc_reg;
        ioc_a_next = ioc_a_reg;
        ioc_b_next = ioc_b_reg;
        irq_en_next = irq_en_reg;
        timer_irq_mask_next = timer_irq_mask_reg;
        if (wr_strobe) begin
            // Gate and mask sit outside the timer and always take writes
            if (paddr_i == `ICAP_OFF_PCE) begin
                timer_clock_gate_next = pwdata_i[`ICAP_PCE_GATE];
            end
            if (paddr_i == `ICAP_OFF_MASK) begin
                timer_irq_mask_next = pwdata_i[`ICAP_MASK_BIT];
            end
            if (timer_clock_gate_reg) begin
                unique case (paddr_i)
                    `ICAP_OFF_MODE: begin
                        count_run_next = pwdata_i[`ICAP_MODE_RUN];
                        filter_clock_select_next = pwdata_i[`ICAP_MODE_FCK_HI:`ICAP_MODE_FCK_LO];
                        filter_enable_a_next = pwdata_i[`ICAP_MODE_DFA];
                        filter_enable_b_next = pwdata_i[`ICAP_MODE_DFB];
                    end
                    `ICAP_OFF_CTRL: cksrc_next = pwdata_i[`ICAP_CTRL_CK_HI:0];
                    // Accepted while running; software stops first
                    `ICAP_OFF_IOC: begin
                        ioc_a_next = pwdata_i[`ICAP_IOC_A_HI:0];
                        ioc_b_next = pwdata_i[`ICAP_IOC_B_HI:`ICAP_IOC_B_LO];
                    end
                    `ICAP_OFF_IEN: irq_en_next = pwdata_i[3:0];
                    default: ;
                endcase
            end
        end
        if (timer_clear) begin
            count_run_next = 1'b0;
            filter_clock_select_next = `ICAP_FCK_RST;
            filter_enable_a_next = 1'b0;
            filter_enable_b_next = 1'b0;
            cksrc_next = `ICAP_CK_RST;
            ioc_a_next = `ICAP_IOC_RST;
            ioc_b_next = `ICAP_IOC_RST;
            irq_en_next = `ICAP_EV_RST;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            timer_clock_gate_reg <= 1'b0;
            count_run_reg <= 1'b0;
            filter_clock_select_reg <= `ICAP_FCK_RST;
            filter_enable_a_reg <= 1'b0;
            filter_enable_b_reg <= 1'b0;
            cksrc_reg <= `ICAP_CK_RST;
            ioc_a_reg <= `ICAP_IOC_RST;
            ioc_b_reg <= `ICAP_IOC_RST;
            irq_en_reg <= `ICAP_EV_RST;
            timer_irq_mask_reg <= `ICAP_MASK_RST;
        end else begin
            timer_clock_gate_reg <= timer_clock_gate_next;
            count_run_reg <= count_run_next;
            filter_clock_select_reg <= filter_clock_select_next;
            filter_enable_a_reg <= filter_enable_a_next;
            filter_enable_b_reg <= filter_enable_b_next;
            cksrc_reg <= cksrc_next;
            ioc_a_reg <= ioc_a_next;
            ioc_b_reg <= ioc_b_next;
            irq_en_reg <= irq_en_next;
            timer_irq_mask_reg <= timer_irq_mask_next;
        end
    end

    // APB answer: one wait state, read data latched with pready
    always_comb begin
        addr_hit = 1'b1;
        prdata_next = prdata_reg;
        unique case (paddr_i)
            `ICAP_OFF_PCE: prdata_next = 32'(timer_clock_gate_reg) << `ICAP_PCE_GATE;
            `ICAP_OFF_MODE: prdata_next = {24'h0, count_run_reg, 1'b0, filter_clock_select_reg,
                filter_enable_b_reg, filter_enable_a_reg, 2'h0};
            `ICAP_OFF_CTRL: prdata_next = {29'h0, cksrc_reg};
            `ICAP_OFF_IOC: prdata_next = {25'h0, ioc_b_reg, 1'b0, ioc_a_reg};
            `ICAP_OFF_IEN: prdata_next = {28'h0, irq_en_reg};
            `ICAP_OFF_STAT: prdata_next = {28'h0, event_reg};
            `ICAP_OFF_MASK: prdata_next = 32'(timer_irq_mask_reg) << `ICAP_MASK_BIT;
            `ICAP_OFF_CNT: prdata_next = 32'(capture_counter_reg);
            `ICAP_OFF_GRA: prdata_next = 32'(general_reg_a_reg);
            `ICAP_OFF_GRB: prdata_next = 32'(general_reg_b_reg);
            default: begin
                addr_hit = 1'b0;
                prdata_next = 32'h0;
            end
        endcase
        pready_next = psel_i & penable_i & ~pready_reg;
        pslverr_next = pready_next & ~addr_hit;
        if (!pready_next || pwrite_i) begin
            prdata_next = 32'h0;
        end
        // Unmasked, enabled events drive the level interrupt
        irq_next = (|(event_reg & irq_en_reg)) & ~timer_irq_mask_reg;
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0;
            irq_reg <= 1'b0;
        end else begin
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            prdata_reg <= prdata_next;
            irq_reg <= irq_next;
        end
    end

    assign prdata_o = prdata_reg;
    assign pready_o = pready_reg;
    assign pslverr_o = pslverr_reg;
    assign timer_irq_o = irq_reg;

endmodule // icap_timer

/* tb/icap_pulse_src.sv */
// Pulse source standing in for the signal on both capture pins.
// Assumes the bench requests levels; each pin changes just after a clock edge.
`timescale 1ns/10ps

module icap_pulse_src (
    input wire logic clk_i,
    input wire logic lvl_a_i,
    input wire logic lvl_b_i,
    output logic pin_a_o,
    output logic pin_b_o
);
    // Flopped so pulse widths are whole clock counts
    always @(posedge clk_i) begin
        pin_a_o <= lvl_a_i;
        pin_b_o <= lvl_b_i;
    end
endmodule // icap_pulse_src

/* tb/icap_timer_assertions.sv */
// Checker for the input capture timer: APB handshake, decode, clock gate and interrupt mask.
// Assumes it is bound to icap_timer and sees only that module's ports.
`timescale 1ns/10ps
`include "icap_defines.svh"

module icap_timer_assertions #(
    parameter int CNT_W = 16,
    parameter int FILT_LEN = 3
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic capture_pin_a_i,
    input wire logic capture_pin_b_i,
    input wire logic timer_irq_o
);
    logic gate_reg, gate_next, mask_reg, mask_next, wr_done, timer_addr;

    // A write lands at its completing edge unless refused
    assign wr_done = psel_i && penable_i && pwrite_i && pready_o && !pslverr_o;
    assign timer_addr = (paddr_i != `ICAP_OFF_PCE) && (paddr_i != `ICAP_OFF_MASK);

    // Mirror of gate and mask
    always_comb begin
        gate_next = gate_reg;
        mask_next = mask_reg;
        if (wr_done && paddr_i == `ICAP_OFF_PCE) begin
            gate_next = pwdata_i[`ICAP_PCE_GATE];
        end
        if (wr_done && paddr_i == `ICAP_OFF_MASK) begin
            mask_next = pwdata_i[`ICAP_MASK_BIT];
        end
    end
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            gate_reg <= 1'b0;
            mask_reg <= `ICAP_MASK_RST;
        end else begin
            gate_reg <= gate_next;
            mask_reg <= mask_next;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    sequence setup_s;
        psel_i && !penable_i;
    endsequence
    sequence wait_s;
        psel_i && penable_i && !pready_o;
    endsequence

    ready_pulse_a: assert property (pready_o |=> !pready_o) else $error("ready longer than one cycle");
    ready_access_a: assert property (pready_o |-> psel_i && penable_i && $past(penable_i))
        else $error("ready outside an access phase");
    ready_latency_a: assert property (setup_s ##1 wait_s |=> pready_o) else $error("ready not after one wait");
    rdata_idle_a: assert property (!pready_o |-> prdata_o == 32'h0) else $error("read data outside ready");
    err_decode_a: assert property (pready_o |-> pslverr_o == (paddr_i > `ICAP_OFF_GRB || paddr_i[1:0] != 2'h0))
        else $error("error flag does not match decode");
    gate_read_a: assert property (pready_o && !pwrite_i && !gate_reg && timer_addr |-> prdata_o == 32'h0)
        else $error("closed gate read not reset value");
    gate_irq_a: assert property ((!gate_reg)[*3] |-> !timer_irq_o)
        else $error("interrupt while gate closed");
    mask_block_a: assert property (timer_irq_o |-> !$past(mask_reg))
        else $error("interrupt passed a set mask");
endmodule // icap_timer_assertions

bind icap_timer icap_timer_assertions #(.CNT_W(CNT_W), .FILT_LEN(FILT_LEN)) u_chk (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .capture_pin_a_i(capture_pin_a_i),
    .capture_pin_b_i(capture_pin_b_i),
    .timer_irq_o(timer_irq_o)
);

/* tb/input_capture_timer_tb.sv */
// Testbench of the input capture timer: APB tasks, pulse source, queue-checked reads.
// Assumes design, pulse source and checker are compiled before it.
`timescale 1ns/10ps
`include "icap_defines.svh"

module input_capture_timer_tb;
    typedef struct packed {
        logic [31:0] data;
        logic [31:0] care;
        logic err;
    } icap_exp_t;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0;
    logic lvl_a = 1'b0;
    logic lvl_b = 1'b0;
    logic [31:0] prdata_o, rd, r1, r2;
    logic pready_o, pslverr_o, timer_irq_o, pin_a, pin_b;
    icap_exp_t exp_q[$];
    icap_exp_t e;
    int errors = 0;
    int checks = 0;
    int cyc = 0;
    int t0, w;
    int div_tab[6] = '{96, 48, 24, 12, 3, 0};
    logic [2:0] ioc_tab[4] = '{3'h4, 3'h5, 3'h6, 3'h2};
    logic [1:0] hit_tab[4] = '{2'h1, 2'h2, 2'h3, 2'h0};

    icap_timer u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .capture_pin_a_i(pin_a), .capture_pin_b_i(pin_b),
        .timer_irq_o(timer_irq_o));
    icap_pulse_src u_src (.clk_i(clk_i), .lvl_a_i(lvl_a), .lvl_b_i(lvl_b), .pin_a_o(pin_a), .pin_b_o(pin_b));

    // 50 MHz clock and a free cycle count for timed spacing
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, want);
        end
    endtask

    // One APB transfer; the expectation is queued for the monitor
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] want, input logic [31:0] care, input logic err);
        exp_q.push_back('{want, care, err});
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        @(posedge clk_i);
        while (pready_o !== 1'b1) @(posedge clk_i);
        rd = prdata_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
    endtask

    task automatic rdx(input logic [11:0] a, input logic [31:0] want, input logic [31:0] care);
        apb(1'b0, a, 32'h0, want, care, 1'b0);
    endtask

    // Counter advance over exactly 96 cycles, a multiple of every divider
    task automatic span(output logic [31:0] diff);
        t0 = cyc;
        rdx(`ICAP_OFF_CNT, 32'h0, 32'h0);
        r1 = rd;
        while (cyc < t0 + 96) @(posedge clk_i);
        rdx(`ICAP_OFF_CNT, 32'h0, 32'h0);
        diff = (rd - r1) & 32'h0000FFFF;
    endtask

    task automatic note(input string s);
        $display("test done: %s", s);
    endtask

    task automatic print_verdict();
        $display("checks %0d, errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Monitor: each completed transfer against the oldest note
    always @(posedge clk_i) begin
        if (psel_i && penable_i && pready_o === 1'b1) begin
            e = exp_q.pop_front();
            check({31'h0, pslverr_o}, {31'h0, e.err});
            check(prdata_o & e.care, e.data);
        end
    end

    // Watchdog, well past the overflow wait
    initial begin
        repeat (100000) @(posedge clk_i);
        errors++;
        print_verdict();
    end

    initial begin
        void'($urandom(32'h46F5FA9C));
        repeat (20) @(posedge clk_i);
        reset_n_i <= 1'b1;
        @(posedge clk_i);
        rdx(`ICAP_OFF_MASK, 32'h8, 32'hFFFFFFFF);
        rdx(`ICAP_OFF_PCE, 32'h0, 32'hFFFFFFFF);
        apb(1'b0, 12'h028, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b1);
        apb(1'b1, 12'h030, 32'hFFFFFFFF, 32'h0, 32'h0, 1'b1);
        wr(`ICAP_OFF_IOC, 32'h66);
        rdx(`ICAP_OFF_IOC, 32'h0, 32'hFFFFFFFF);
        note("reset values and closed gate");
        wr(`ICAP_OFF_PCE, 32'h40);
        wr(`ICAP_OFF_IOC, 32'h66);
        rdx(`ICAP_OFF_IOC, 32'h66, 32'hFFFFFFFF);
        wr(`ICAP_OFF_IEN, 32'hB);
        rdx(`ICAP_OFF_IEN, 32'hB, 32'hFFFFFFFF);
        for (int ck = 0; ck < 6; ck++) begin
            wr(`ICAP_OFF_CTRL, 32'(ck));
            wr(`ICAP_OFF_MODE, 32'h80);
            span(r2);
            check(r2, 32'(div_tab[ck]));
        end
        wr(`ICAP_OFF_CTRL, 32'h0);
        wr(`ICAP_OFF_MODE, 32'h0);
        span(r2);
        check(r2, 32'h0);
        note("count sources and run bit");
        // Edge modes on both channels, compare mode last
        for (int m = 0; m < 4; m++) begin
            wr(`ICAP_OFF_MODE, 32'h0);
            wr(`ICAP_OFF_IOC, {25'h0, ioc_tab[m], 1'b0, ioc_tab[m]});
            wr(`ICAP_OFF_STAT, 32'hB);
            wr(`ICAP_OFF_MODE, 32'h80);
            lvl_a <= 1'b1;
            lvl_b <= 1'b1;
            repeat (10) @(posedge clk_i);
            rdx(`ICAP_OFF_STAT, {30'h0, {2{hit_tab[m][0]}}}, 32'h3);
            wr(`ICAP_OFF_STAT, 32'h3);
            lvl_a <= 1'b0;
            lvl_b <= 1'b0;
            repeat (10) @(posedge clk_i);
            rdx(`ICAP_OFF_STAT, {30'h0, {2{hit_tab[m][1]}}}, 32'h3);
        end
        note("edge selection");
        wr(`ICAP_OFF_IOC, 32'h66);
        wr(`ICAP_OFF_IEN, 32'h1);
        wr(`ICAP_OFF_MASK, 32'h0);
        // Pulse width on both edges, then with the filter on
        for (int f = 0; f < 2; f++) begin
            wr(`ICAP_OFF_MODE, 32'h0);
            wr(`ICAP_OFF_STAT, 32'hB);
            wr(`ICAP_OFF_MODE, f ? 32'hAC : 32'h80);
            w = 40 + $urandom % 40;
            t0 = cyc;
            lvl_a <= 1'b1;
            lvl_b <= 1'b1;
            repeat (15) @(posedge clk_i);
            rdx(`ICAP_OFF_GRA, 32'h0, 32'h0);
            r1 = rd;
            rdx(`ICAP_OFF_GRB, 32'h0, 32'h0);
            check(rd, r1);
            while (cyc < t0 + w) @(posedge clk_i);
            lvl_a <= 1'b0;
            lvl_b <= 1'b0;
            repeat (15) @(posedge clk_i);
            rdx(`ICAP_OFF_GRA, 32'h0, 32'h0);
            check((rd - r1) & 32'h0000FFFF, 32'(w));
            check({31'h0, timer_irq_o}, 32'h1);
            wr(`ICAP_OFF_MASK, 32'h8);
            repeat (3) @(posedge clk_i);
            check({31'h0, timer_irq_o}, 32'h0);
            wr(`ICAP_OFF_MASK, 32'h0);
        end
        wr(`ICAP_OFF_STAT, 32'hB);
        lvl_a <= 1'b1;
        repeat (2) @(posedge clk_i);
        lvl_a <= 1'b0;
        repeat (20) @(posedge clk_i);
        rdx(`ICAP_OFF_STAT, 32'h0, 32'h1);
        note("pulse width, interrupt and filter");
        wr(`ICAP_OFF_MODE, 32'h0);
        wr(`ICAP_OFF_IOC, 32'h0);
        wr(`ICAP_OFF_IEN, 32'h8);
        wr(`ICAP_OFF_STAT, 32'hB);
        wr(`ICAP_OFF_MODE, 32'h80);
        t0 = cyc;
        while (timer_irq_o !== 1'b1 && cyc < t0 + 70000) @(posedge clk_i);
        check({31'h0, timer_irq_o}, 32'h1);
        rdx(`ICAP_OFF_STAT, 32'h8, 32'h8);
        wr(`ICAP_OFF_STAT, 32'h8);
        rdx(`ICAP_OFF_STAT, 32'h0, 32'h8);
        rdx(`ICAP_OFF_CNT, 32'h0, 32'hFFFFF000);
        note("overflow");
        wr(`ICAP_OFF_PCE, 32'h0);
        wr(`ICAP_OFF_PCE, 32'h40);
        rdx(`ICAP_OFF_GRA, 32'h0, 32'hFFFFFFFF);
        rdx(`ICAP_OFF_MODE, 32'h0, 32'hFFFFFFFF);
        rdx(`ICAP_OFF_IEN, 32'h0, 32'hFFFFFFFF);
        note("gate off resets timer");
        print_verdict();
    end
endmodule // input_capture_timer_tb
